// [verilog/ingress_switch_cell_segmenter.sv]
`include "segmenter_regs.svh"
`default_nettype none
module ingress_switch_cell_segmenter (
    input wire logic clock,
    input wire logic reset,
    input wire logic [4:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdData,
    input wire logic descValid,
    output logic descReady,
    input wire logic [15:0] descBufAddr,
    input wire logic [15:0] descNextBufAddr,
    input wire logic [13:0] descLength,
    input wire logic [15:0] descTarget,
    input wire logic [1:0] descPrio,
    input wire logic descUnicast,
    input wire logic descGuided,
    input wire logic [3:0] descFlowClass,
    input wire logic [5:0] descCorrelator,
    input wire logic descAbort,
    input wire logic [79:0] descFrameHdr,
    input wire logic nextValid,
    input wire logic nextUnicast,
    input wire logic [15:0] nextTarget,
    input wire logic [1:0] nextPrio,
    input wire logic [13:0] nextLength,
    input wire logic [5:0] nextCorrelator,
    input wire logic dataValid,
    output logic dataReady,
    input wire logic [7:0] dataByte,
    output logic cellReq,
    input wire logic cellGrant,
    output logic cellValid,
    output logic [7:0] cellByte,
    output logic cellLast
);
    segmenter_pkg::seg_s s, n;
    logic wrEn;
    logic [7:0] wrByte;
    logic uc, tagHere, packOk;
    logic [6:0] base, qwStart;
    logic [1:0] st, fmt;
    logic [5:0] ep;
    logic [7:0] h0;

    // Unicast target blade field coded per blade mode
    function automatic logic [15:0] mapTb(input logic [1:0] mode,
            input logic u, input logic [15:0] t);
        logic [15:0] r;
        r = t;
        if (u && mode == `SEG_MODE16)
            r = 16'h8000 >> t[3:0];
        else if (u && mode == `SEG_MODE32)
            r = t & 16'h001f;
        else if (u)
            r = t & 16'h003f;
        return r;
    endfunction

    function automatic logic [5:0] maskCorr(input logic [1:0] mode,
            input logic u, input logic [5:0] c);
        logic [5:0] m;
        m = 6'h07;
        if (mode == `SEG_MODE16)
            m = u ? 6'h3f : 6'h1f;
        else if (mode == `SEG_MODE32)
            m = u ? 6'h1f : 6'h0f;
        else
            m = u ? 6'h1f : 6'h07;
        return c & m;
    endfunction

    // VLAN tag bytes in outgoing order
    function automatic logic [7:0] tagByte(input logic [13:0] idx,
            input logic [15:0] tc);
        logic [7:0] b;
        unique case (idx[1:0])
            2'h0: b = `SEG_TPID_HI;
            2'h1: b = `SEG_TPID_LO;
            2'h2: b = tc[15:8];
            default: b = tc[7:0];
        endcase
        return b;
    endfunction

    // Next-state logic for the whole block
    always_comb begin
        n = s;
        wrEn = 1'b0;
        wrByte = `SEG_PAD;
        uc = descUnicast & ~descGuided;
        base = `SEG_HDR_LEN;
        qwStart = (s.pos + `SEG_QW_ROUND) & `SEG_QW_MASK;
        tagHere = s.vlanEn && s.outIdx >= `SEG_VLAN_POS &&
            s.outIdx < `SEG_VLAN_END;
        packOk = s.fUc && s.nValid && s.nUc && s.nTb == s.fTb &&
            s.nPrio == s.fPrio && s.nLen >= `SEG_PACK_MIN_LEN &&
            s.nCorr != s.hCorr;
        st = {s.cStart, s.cEnd};
        fmt = `SEG_FMT_SINGLE;
        ep = s.cEnd ? s.endPtr : s.seq;
        h0 = 8'h00;
        n.rdData = 32'h0;
        n.cellValid = 1'b0;
        n.cellLast = 1'b0;
        // Register writes
        if (regWrite) begin
            unique case (regAddr)
                `SEG_CTRL_ADDR: begin
                    n.vlanEn = regWrData[0];
                    n.overlay = regWrData[1];
                    n.bladeMode = regWrData[3:2];
                end
                `SEG_TAG_ADDR: n.tag = regWrData[15:0];
                `SEG_DEL_ADDR: n.delN = regWrData[5:0];
                default: ;
            endcase
        end
        // Register reads, unmapped reads zero
        if (regRead) begin
            unique case (regAddr)
                `SEG_CTRL_ADDR:
                    n.rdData = {28'h0, s.bladeMode, s.overlay, s.vlanEn};
                `SEG_TAG_ADDR: n.rdData = {16'h0, s.tag};
                `SEG_DEL_ADDR: n.rdData = {26'h0, s.delN};
                `SEG_STAT_ADDR: n.rdData = {10'h0, s.state, s.cellCnt};
                `SEG_BUF_ADDR: n.rdData = {s.nextAddr, s.bufAddr};
                default: n.rdData = 32'h0;
            endcase
        end
        unique case (s.state)
            segmenter_pkg::S_IDLE, segmenter_pkg::S_PACKWAIT: begin
                if (descValid && s.descReady) begin
                    n.bufAddr = descBufAddr;
                    n.nextAddr = descNextBufAddr;
                    n.fUc = uc;
                    n.fTb = mapTb(s.bladeMode, uc, descTarget);
                    n.fPrio = descPrio;
                    n.fCorr = maskCorr(s.bladeMode, uc, descCorrelator);
                    n.fQt = {descGuided, descFlowClass == `SEG_FC_NODROP};
                    n.nValid = nextValid;
                    n.nUc = nextUnicast;
                    n.nTb = mapTb(s.bladeMode, nextUnicast, nextTarget);
                    n.nPrio = nextPrio;
                    n.nLen = nextLength;
                    n.nCorr = maskCorr(s.bladeMode, nextUnicast,
                        nextCorrelator);
                    n.outIdx = 14'h0;
                    n.inCnt = 6'h0;
                    n.outLen = descLength - {8'h0, s.delN} +
                        ((s.vlanEn && !s.overlay) ? `SEG_VLAN_LEN : 14'h0);
                    n.seq = 6'h0;
                    if (s.state == segmenter_pkg::S_IDLE) begin
                        n.hUc = uc;
                        n.hTb = n.fTb;
                        n.hPrio = descPrio;
                        n.hCorr = n.fCorr;
                        n.hQt = n.fQt;
                        n.cStart = 1'b1;
                        n.cEnd = 1'b0;
                        n.packCell = 1'b0;
                    end else begin
                        base = s.pos;
                    end
                    if (descAbort && s.state == segmenter_pkg::S_IDLE) begin
                        n.abort = 1'b1;
                        n.pos = `SEG_HDR_LEN;
                        n.state = segmenter_pkg::S_CLOSE;
                    end else begin
                        // frame header follows the cell header, or starts at pos after the padded previous frame when packing
                        for (int i = 0; i < 10; i++) begin
                            n.cellBuf[6'(base + 7'(i))] =
                                descFrameHdr[79 - 8 * i -: 8];
                        end
                        n.pos = base + `SEG_FH_LEN;
                        n.state = segmenter_pkg::S_DATA;
                    end
                end
            end
            segmenter_pkg::S_DATA: begin
                if (s.outIdx == s.outLen) begin
                    // end offset of last data byte
                    n.cEnd = 1'b1;
                    n.endPtr = 6'(s.pos - 7'h01);
                    if (packOk && qwStart <= `SEG_PACK_MAX) begin
                        for (int i = 0; i < 64; i++) begin
                            if (7'(i) >= s.pos && 7'(i) < qwStart)
                                n.cellBuf[i] = `SEG_PAD;
                        end
                        n.packCell = 1'b1;
                        n.pos = qwStart;
                        n.state = segmenter_pkg::S_PACKWAIT;
                    end else begin
                        n.state = segmenter_pkg::S_CLOSE;
                    end
                end else if (s.pos == `SEG_CELL_LEN) begin
                    n.state = segmenter_pkg::S_CLOSE;
                end else if (tagHere && !s.overlay) begin
                    wrEn = 1'b1;
                    wrByte = tagByte(s.outIdx, s.tag);
                end else if (dataValid && s.dataReady) begin
                    if (s.inCnt < s.delN) begin
                        n.inCnt = s.inCnt + 6'h01;
                    end else begin
                        wrEn = 1'b1;
                        wrByte = tagHere ? tagByte(s.outIdx, s.tag) :
                            dataByte;
                    end
                end
                if (wrEn) begin
                    n.cellBuf[s.pos[5:0]] = wrByte;
                    n.pos = s.pos + 7'h01;
                    n.outIdx = s.outIdx + 14'h1;
                end
            end
            segmenter_pkg::S_CLOSE: begin
                for (int i = 0; i < 64; i++) begin
                    if (7'(i) >= s.pos)
                        n.cellBuf[i] = `SEG_PAD;
                end
                if (s.abort) begin
                    st = `SEG_ST_SE;
                    ep = 6'h0;
                end else if (s.packCell) begin
                    st = `SEG_ST_END;
                    fmt = `SEG_FMT_PACKED;
                end
                h0 = {fmt[1], 1'b0, `SEG_DATA_CELL, 1'b0, fmt[0], s.hPrio};
                h0[6] = ^{h0, s.hTb};
                n.cellBuf[0] = h0;
                n.cellBuf[1] = s.hTb[15:8];
                n.cellBuf[2] = s.hTb[7:0];
                n.cellBuf[3] = {s.hUc, st, s.hQt, 3'h0};
                n.cellBuf[4] = {2'h0, s.hCorr};
                n.cellBuf[5] = {2'h0, ep};
                n.state = segmenter_pkg::S_REQ;
            end
            segmenter_pkg::S_REQ: begin
                if (cellGrant) begin
                    n.sendIdx = 6'h0;
                    n.state = segmenter_pkg::S_SEND;
                end
            end
            segmenter_pkg::S_SEND: begin
                n.cellValid = 1'b1;
                n.cellByte = s.cellBuf[s.sendIdx];
                n.cellLast = s.sendIdx == `SEG_LAST_IDX;
                n.sendIdx = s.sendIdx + 6'h01;
                if (s.sendIdx == `SEG_LAST_IDX) begin
                    n.cellCnt = s.cellCnt + 16'h1;
                    if (s.abort || (s.cEnd && !s.packCell)) begin
                        n.abort = 1'b0;
                        n.state = segmenter_pkg::S_IDLE;
                    end else begin
                        n.seq = s.seq + 6'h01;
                        n.pos = `SEG_HDR_LEN;
                        n.cStart = 1'b0;
                        n.cEnd = 1'b0;
                        n.packCell = 1'b0;
                        n.hUc = s.fUc;
                        n.hTb = s.fTb;
                        n.hPrio = s.fPrio;
                        n.hCorr = s.fCorr;
                        n.hQt = s.fQt;
                        n.state = segmenter_pkg::S_DATA;
                    end
                end
            end
        endcase
        // Registered handshake outputs
        n.cellReq = n.state == segmenter_pkg::S_REQ;
        n.descReady = n.state == segmenter_pkg::S_IDLE ||
            n.state == segmenter_pkg::S_PACKWAIT;
        n.dataReady = n.state == segmenter_pkg::S_DATA &&
            n.outIdx != n.outLen && n.pos != `SEG_CELL_LEN &&
            !(n.vlanEn && !n.overlay && n.outIdx >= `SEG_VLAN_POS &&
            n.outIdx < `SEG_VLAN_END);
    end

    // State register
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s <= '0;
            s.state <= segmenter_pkg::S_IDLE;
            s.descReady <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from flops
    assign regRdData = s.rdData;
    assign descReady = s.descReady;
    assign dataReady = s.dataReady;
    assign cellReq = s.cellReq;
    assign cellValid = s.cellValid;
    assign cellByte = s.cellByte;
    assign cellLast = s.cellLast;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    property p_tpid;
        (wrEn && s.vlanEn && s.outIdx == `SEG_VLAN_POS) |->
            wrByte == `SEG_TPID_HI;
    endproperty
    a_tpid: assert property (p_tpid)
        else $error("tag type byte wrong");

    property p_first;
        (s.state == segmenter_pkg::S_IDLE && descValid && s.descReady &&
            !descAbort) |=> (s.pos == `SEG_FIRST_DATA &&
            s.state == segmenter_pkg::S_DATA);
    endproperty
    a_first: assert property (p_first)
        else $error("first cell data does not follow frame header");

    property p_follow;
        (s.state == segmenter_pkg::S_SEND && s.sendIdx == `SEG_LAST_IDX &&
            !s.abort && !(s.cEnd && !s.packCell)) |=> s.pos == `SEG_HDR_LEN;
    endproperty
    a_follow: assert property (p_follow)
        else $error("following cell data not after header");

    property p_packAlign;
        (s.state == segmenter_pkg::S_PACKWAIT) |->
            (s.pos[3:0] == 4'h0 && s.pos <= `SEG_PACK_MAX);
    endproperty
    a_packAlign: assert property (p_packAlign)
        else $error("packed frame not on quadword boundary");

    property p_grant;
        $rose(cellValid) |-> $past(cellGrant, 2) && $past(cellReq, 2);
    endproperty
    a_grant: assert property (p_grant)
        else $error("cell sent without grant");

    property p_cellLen;
        $rose(cellValid) |-> ##63 (cellLast && cellValid);
    endproperty
    a_cellLen: assert property (p_cellLen)
        else $error("cell not 64 bytes");

    property p_qual;
        $rose(cellValid) |-> (cellByte[5:4] == `SEG_DATA_CELL &&
            !cellByte[3] && cellByte[1:0] != `SEG_PRIO_RSVD);
    endproperty
    a_qual: assert property (p_qual)
        else $error("qualifier coding wrong");

    property p_parity;
        (s.state == segmenter_pkg::S_REQ) |->
            ^{s.cellBuf[0], s.cellBuf[1], s.cellBuf[2]} == 1'b0;
    endproperty
    a_parity: assert property (p_parity)
        else $error("header parity not even");

    property p_packSt;
        (s.state == segmenter_pkg::S_CLOSE && s.packCell) |=>
            (s.cellBuf[3][6:5] == `SEG_ST_END && s.cellBuf[0][7] &&
            s.cellBuf[0][2]);
    endproperty
    a_packSt: assert property (p_packSt)
        else $error("packed cell format or state wrong");

    property p_seq;
        (s.state == segmenter_pkg::S_SEND && s.sendIdx == `SEG_LAST_IDX &&
            !s.cEnd && !s.abort) |=> s.seq == 6'($past(s.seq) + 6'h01);
    endproperty
    a_seq: assert property (p_seq)
        else $error("sequence number did not advance");

    property p_endptr;
        (s.state == segmenter_pkg::S_REQ &&
            s.cellBuf[3][6:5] == `SEG_ST_END) |->
            s.cellBuf[5][5:0] >= `SEG_MIN_ENDPTR;
    endproperty
    a_endptr: assert property (p_endptr)
        else $error("end offset out of range");

    c_packed: cover property (s.state == segmenter_pkg::S_PACKWAIT &&
        descValid && s.descReady);
    c_vlan: cover property (wrEn && s.vlanEn && !s.overlay);
    c_abort: cover property (s.state == segmenter_pkg::S_CLOSE && s.abort);
endmodule
`default_nettype wire

// [verilog/segmenter_regs.svh]
`ifndef SEGMENTER_REGS_SVH
`define SEGMENTER_REGS_SVH
`define SEG_CTRL_ADDR 5'h00
`define SEG_TAG_ADDR 5'h04
`define SEG_DEL_ADDR 5'h08
`define SEG_STAT_ADDR 5'h0c
`define SEG_BUF_ADDR 5'h10
`define SEG_HDR_LEN 7'h06
`define SEG_FH_LEN 7'h0a
`define SEG_FIRST_DATA 7'h10
`define SEG_CELL_LEN 7'h40
`define SEG_LAST_IDX 6'h3f
`define SEG_QW_ROUND 7'h0f
`define SEG_QW_MASK 7'h70
`define SEG_PACK_MAX 7'h30
`define SEG_PACK_MIN_LEN 14'h0031
`define SEG_VLAN_POS 14'h000c
`define SEG_VLAN_END 14'h0010
`define SEG_VLAN_LEN 14'h0004
`define SEG_TPID_HI 8'h81
`define SEG_TPID_LO 8'h00
`define SEG_PAD 8'h00
`define SEG_FC_NODROP 4'hf
`define SEG_MIN_ENDPTR 6'h06
`define SEG_DATA_CELL 2'h3
`define SEG_PRIO_RSVD 2'h3
`define SEG_ST_CONT 2'h0
`define SEG_ST_END 2'h1
`define SEG_ST_SE 2'h3
`define SEG_FMT_SINGLE 2'h2
`define SEG_FMT_PACKED 2'h3
`define SEG_MODE16 2'h0
`define SEG_MODE32 2'h1
`endif

// [verilog/segmenter_pkg.sv]
`default_nettype none
package segmenter_pkg;
    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_DATA = 6'h02,
        S_PACKWAIT = 6'h04,
        S_CLOSE = 6'h08,
        S_REQ = 6'h10,
        S_SEND = 6'h20
    } state_e;
    typedef struct packed {
        state_e state;
        logic [63:0][7:0] cellBuf;
        logic [6:0] pos;
        logic [5:0] sendIdx;
        logic [13:0] outIdx, outLen;
        logic [5:0] inCnt;
        logic abort, fUc;
        logic [15:0] fTb;
        logic [1:0] fPrio, fQt;
        logic [5:0] fCorr;
        logic hUc;
        logic [15:0] hTb;
        logic [1:0] hPrio, hQt;
        logic [5:0] hCorr;
        logic nValid, nUc;
        logic [15:0] nTb;
        logic [1:0] nPrio;
        logic [13:0] nLen;
        logic [5:0] nCorr;
        logic cStart, cEnd, packCell;
        logic [5:0] endPtr, seq;
        logic vlanEn, overlay;
        logic [1:0] bladeMode;
        logic [15:0] tag;
        logic [5:0] delN;
        logic [15:0] cellCnt, bufAddr, nextAddr;
        logic descReady, dataReady, cellReq, cellValid, cellLast;
        logic [7:0] cellByte;
        logic [31:0] rdData;
    } seg_s;
endpackage
`default_nettype wire

// [verification/cell_link_model.sv]
`default_nettype none
module cell_link_model (
    input wire logic clock,
    input wire logic reset,
    input wire logic slow,
    input wire logic cellReq,
    output logic cellGrant,
    input wire logic cellValid,
    input wire logic [7:0] cellByte,
    input wire logic cellLast
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:7][0:63];
    logic [2:0] hold;
    int cellCount;
    int idx;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cellGrant <= 1'b0;
            hold <= 3'h0;
        end else begin
            cellGrant <= cellReq && !cellGrant && hold == 3'h0;
            if (!cellReq)
                hold <= slow ? 3'h5 : 3'h0; // Slow mode delays grant
            else if (hold != 3'h0)
                hold <= hold - 3'h1;
        end
    end
    // Capture each streamed cell
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cellCount <= 0;
            idx <= 0;
        end else if (cellValid) begin
            mem[cellCount[2:0]][idx] <= cellByte;
            idx <= cellLast ? 0 : idx + 1;
            if (cellLast)
                cellCount <= cellCount + 1;
        end
    end
endmodule
`default_nettype wire

// [verification/testbench.sv]
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, reset, regWrite, regRead, descValid, descReady, descUnicast;
    logic descGuided, nextValid, nextUnicast, dataValid, dataReady, slow;
    logic descAbort;
    logic cellReq, cellGrant, cellValid, cellLast;
    logic [4:0] regAddr;
    logic [31:0] regWrData, regRdData;
    logic [15:0] descTarget, nextTarget;
    logic [13:0] descLength, nextLength;
    logic [1:0] descPrio, nextPrio;
    logic [3:0] descFlowClass;
    logic [5:0] descCorrelator, nextCorrelator;
    logic [7:0] dataByte, cellByte;
    logic [7:0] exp [0:7][0:63];
    int fails, checked, cycles, base;

    ingress_switch_cell_segmenter u_ingress_switch_cell_segmenter (
        .clock, .reset, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
        .descValid, .descReady, .descBufAddr(16'h0100),
        .descNextBufAddr(16'h0200), .descLength, .descTarget, .descPrio,
        .descUnicast, .descGuided, .descFlowClass, .descCorrelator,
        .descAbort, .descFrameHdr(80'h00112233445566778899),
        .nextValid, .nextUnicast, .nextTarget, .nextPrio, .nextLength,
        .nextCorrelator, .dataValid, .dataReady, .dataByte, .cellReq,
        .cellGrant, .cellValid, .cellByte, .cellLast);
    cell_link_model u_cell_link_model (.clock, .reset, .slow, .cellReq,
        .cellGrant, .cellValid, .cellByte, .cellLast);

    // Clock generator
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            results();
        end
    end

    task automatic results();
        $display("Checks %0d, errors %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp(input string what, input int n, input logic [31:0] e,
        input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("Error %s %0d expected %h seen %h", what, n, e, g);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clock);
        {regAddr, regWrData, regWrite} <= {a, d, 1'b1};
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        @(posedge clock);
        {regAddr, regRead} <= {a, 1'b1};
        @(posedge clock);
        regRead <= 1'b0;
        @(negedge clock);
        cmp("reg", a, e, regRdData);
    endtask
    // Offer a descriptor, then stream its bytes
    // scheduler descriptor supply
    task automatic desc(input logic [13:0] len, input logic [15:0] tb,
        input logic [1:0] pr, input logic uc, input logic gd,
        input logic [3:0] fc, input logic [5:0] co, input logic [7:0] b);
        @(posedge clock);
        {descLength, descTarget, descPrio, descUnicast, descGuided,
            descFlowClass, descCorrelator} <= {len, tb, pr, uc, gd, fc, co};
        descValid <= 1'b1;
        do @(negedge clock); while (descReady !== 1'b1);
        @(posedge clock);
        descValid <= 1'b0;
        for (int i = 0; i < len; i++) begin
            dataByte <= b + 8'(i);
            dataValid <= 1'b1;
            do @(negedge clock); while (dataReady !== 1'b1);
            @(posedge clock);
        end
        dataValid <= 1'b0;
    endtask
    // Expected header with even parity over qualifier and target
    task automatic hdr(input int c, input logic [7:0] h0,
        input logic [15:0] tb, input logic [7:0] h3, h4, h5);
        exp[c][0] = h0 | {1'b0, ^{h0, tb}, 6'h00};
        {exp[c][1], exp[c][2], exp[c][3], exp[c][4], exp[c][5]} =
            {tb, h3, h4, h5};
    endtask
    task automatic fh(input int c, input int p);
        for (int j = 0; j < 10; j++)
            exp[c][p + j] = 8'h11 * 8'(j);
    endtask
    task automatic dat(input int c, input int p, input int n,
        input logic [7:0] b);
        for (int i = 0; i < n; i++)
            exp[c][p + i] = b + 8'(i);
    endtask
    task automatic checkCells(input int n);
        for (int i = 0; i < 3000 && u_cell_link_model.cellCount < base + n; i++)
            @(negedge clock);
        for (int c = 0; c < n; c++)
            for (int k = 0; k < 64; k++)
                cmp("cellByte", c * 64 + k, exp[c][k],
                    u_cell_link_model.mem[base + c][k]);
        base = base + n;
        for (int c = 0; c < 8; c++)
            for (int k = 0; k < 64; k++)
                exp[c][k] = 8'h00;
    endtask

    task automatic shortFrame();
        nextValid <= 1'b0;
        desc(14'd20, 16'h0003, 2'h1, 1'b1, 1'b0, 4'hf, 6'h05, 8'h00);
        hdr(0, 8'hb1, 16'h1000, 8'he8, 8'h05, 8'h23);
        fh(0, 6);
        dat(0, 16, 20, 8'h00);
        checkCells(1);
    endtask
    task automatic regAccess();
        rd(5'h00, 32'h0);
        wr(5'h04, 32'h0000abcd);
        wr(5'h08, 32'h00000002);
        wr(5'h14, 32'hffffffff);
        rd(5'h04, 32'h0000abcd);
        rd(5'h08, 32'h00000002);
        rd(5'h14, 32'h0);
        rd(5'h0c, 32'h00010001);
        rd(5'h10, 32'h02000100);
    endtask
    task automatic longFrame();
        logic [31:0] tagWord;
        logic [7:0] v;
        int q;
        tagWord = 32'h8100abcd;
        wr(5'h00, 32'h1);
        slow <= 1'b1;
        desc(14'd110, 16'h00f0, 2'h2, 1'b1, 1'b1, 4'h0, 6'h07, 8'h00);
        hdr(0, 8'hb2, 16'h00f0, 8'h50, 8'h07, 8'h00);
        hdr(1, 8'hb2, 16'h00f0, 8'h10, 8'h07, 8'h01);
        hdr(2, 8'hb2, 16'h00f0, 8'h30, 8'h07, 8'h0b);
        fh(0, 6);
        for (int k = 0; k < 112; k++) begin
            v = k < 12 ? 8'(k + 2) : 8'(k - 2);
            if (k >= 12 && k < 16)
                v = tagWord[8 * (15 - k) +: 8];
            q = k - 48;
            if (k < 48)
                exp[0][16 + k] = v;
            else
                exp[1 + q / 58][6 + q % 58] = v;
        end
        checkCells(3);
        slow <= 1'b0;
    endtask
    task automatic packedPair();
        wr(5'h00, 32'h3);
        wr(5'h08, 32'h0);
        {nextValid, nextUnicast, nextTarget, nextPrio, nextLength,
            nextCorrelator} <= {1'b1, 1'b1, 16'h0003, 2'h1, 14'd60, 6'h09};
        desc(14'd20, 16'h0003, 2'h1, 1'b1, 1'b0, 4'h0, 6'h05, 8'h00);
        nextValid <= 1'b0;
        desc(14'd60, 16'h0003, 2'h1, 1'b1, 1'b0, 4'h0, 6'h09, 8'h80);
        hdr(0, 8'hb5, 16'h1000, 8'ha0, 8'h05, 8'h23);
        fh(0, 6);
        dat(0, 16, 20, 8'h00);
        {exp[0][28], exp[0][29], exp[0][30], exp[0][31]} = 32'h8100abcd;
        fh(0, 48);
        dat(0, 58, 6, 8'h80);
        hdr(1, 8'hb1, 16'h1000, 8'ha0, 8'h09, 8'h3b);
        dat(1, 6, 54, 8'h86);
        {exp[1][12], exp[1][13], exp[1][14], exp[1][15]} = 32'h8100abcd;
        checkCells(2);
    endtask
    task automatic abortCell();
        wr(5'h00, 32'h00000004);
        descAbort <= 1'b1;
        desc(14'd0, 16'h0025, 2'h1, 1'b1, 1'b0, 4'hf, 6'h3f, 8'h00);
        descAbort <= 1'b0;
        hdr(0, 8'hb1, 16'h0005, 8'he8, 8'h1f, 8'h00);
        checkCells(1);
    endtask

    // Main sequence
    initial begin
        {reset, regWrite, regRead, descValid, descUnicast, descGuided} = 6'h20;
        {nextValid, nextUnicast, dataValid, slow, regAddr, regWrData} = '0;
        {descTarget, nextTarget, descLength, nextLength, descPrio} = '0;
        {nextPrio, descFlowClass, descCorrelator, nextCorrelator} = '0;
        dataByte = 8'h00;
        descAbort = 1'b0;
        {fails, checked, cycles, base} = '0;
        for (int c = 0; c < 8; c++)
            for (int k = 0; k < 64; k++)
                exp[c][k] = 8'h00;
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        shortFrame();
        regAccess();
        longFrame();
        packedPair();
        abortCell();
        results();
    end
endmodule
`default_nettype wire
